/* adc_sample_convert_control.sv */
// Chosen here: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module adc_sample_convert_control
(
   // System
   input wire logic clk,
   input wire logic rstn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [11:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Trigger pins
   input wire logic extInt0,
   input wire logic timer3Compare,
   input wire logic pwm1Interval,
   input wire logic pwm2Interval,
   // Converter side
   output logic sampling,
   output logic convertStart,
   output logic simultaneous,
   output logic [1:0] channelSample,
   // Interrupt
   output logic irq
);
   trig_if trig();
   assign trig.rawExt0 = extInt0;
   assign trig.rawTmr3 = timer3Compare;
   assign trig.rawPwm1 = pwm1Interval;
   assign trig.rawPwm2 = pwm2Interval;
   trig_sync u_sync
   (
      .clk(clk),
      .rstn(rstn),
      .trig(trig)
   );

   adc_ctrl_pkg::conv_state_t state;
   logic [2:0] triggerSource;
   logic sampleAuto;
   logic simSample;
   logic resolution;
   logic sampleEnable;
   logic convDone;
   logic [1:0] channelCount;
   logic [4:0] autoCount;
   logic [7:0] convCycles;
   logic [7:0] counter;
   logic [1:0] chanIdx;
   logic [adc_ctrl_pkg::IRQ_W-1:0] irqStatus;
   logic [adc_ctrl_pkg::IRQ_W-1:0] irqMask;

   // AHB address phase capture
   logic wrPend;
   logic rdPend;
   logic [11:0] addrPend;
   wire logic addrValid = hsel & hready & htrans[1];
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         wrPend <= 1'b0;
         rdPend <= 1'b0;
         addrPend <= 12'h000;
      end
      else
      begin
         wrPend <= addrValid & hwrite;
         rdPend <= addrValid & ~hwrite;
         if (addrValid)
            addrPend <= haddr;
      end
   end

   wire logic ctlWr = wrPend && addrPend == adc_ctrl_pkg::ADDR_CONTROL_1;
   wire logic cfgWr = wrPend && addrPend == adc_ctrl_pkg::ADDR_CONFIG;
   wire logic swSampleSet = ctlWr & ~sampleEnable
      & hwdata[adc_ctrl_pkg::BIT_SAMPLE_ENABLE];
   wire logic swSampleClr = ctlWr & sampleEnable
      & ~hwdata[adc_ctrl_pkg::BIT_SAMPLE_ENABLE];
   wire logic doneSwClr = ctlWr & ~hwdata[adc_ctrl_pkg::BIT_CONV_DONE];

   // Trigger selection
   logic hwTrigger;
   always_comb
   begin
      unique case (triggerSource)
         adc_ctrl_pkg::TRIG_EXT0: hwTrigger = trig.ext0Edge;
         adc_ctrl_pkg::TRIG_TMR3: hwTrigger = trig.tmr3Pulse;
         adc_ctrl_pkg::TRIG_PWM1: hwTrigger = trig.pwm1Pulse;
         adc_ctrl_pkg::TRIG_PWM2: hwTrigger = trig.pwm2Pulse;
         adc_ctrl_pkg::TRIG_AUTO: hwTrigger = counter == 8'(autoCount);
         default: hwTrigger = 1'b0; // Reserved codes never trigger
      endcase
   end

   wire logic softMode = triggerSource == adc_ctrl_pkg::TRIG_SOFT;
   wire logic startConv = state == adc_ctrl_pkg::ST_SAMPLE
      && (softMode ? swSampleClr : hwTrigger);
   wire logic convEnd = state == adc_ctrl_pkg::ST_CONVERT
      && counter == convCycles;

   // Configuration fields
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         triggerSource <= adc_ctrl_pkg::TRIG_SOFT;
         sampleAuto <= 1'b0;
         simSample <= 1'b0;
         resolution <= 1'b0;
         channelCount <= adc_ctrl_pkg::CHANNEL_COUNT_SELECT_RESET;
         autoCount <= adc_ctrl_pkg::AUTO_COUNT_RESET;
         convCycles <= adc_ctrl_pkg::CONV_CYCLES_RESET;
      end
      else
      begin
         if (ctlWr)
         begin
            triggerSource <=
               hwdata[adc_ctrl_pkg::TRIG_MSB:adc_ctrl_pkg::TRIG_LSB];
            sampleAuto <= hwdata[adc_ctrl_pkg::BIT_SAMPLE_AUTO];
            simSample <= hwdata[adc_ctrl_pkg::BIT_SIM_SAMPLE];
            resolution <= hwdata[adc_ctrl_pkg::BIT_RESOLUTION];
         end
         if (cfgWr)
         begin
            channelCount <=
               hwdata[adc_ctrl_pkg::CHANNEL_COUNT_SELECT_MSB:adc_ctrl_pkg::CHANNEL_COUNT_SELECT_LSB];
            autoCount <=
               hwdata[adc_ctrl_pkg::ACNT_MSB:adc_ctrl_pkg::ACNT_LSB];
            convCycles <=
               hwdata[adc_ctrl_pkg::CONV_MSB:adc_ctrl_pkg::CONV_LSB];
         end
      end
   end

   // Sequencer
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         state <= adc_ctrl_pkg::ST_IDLE;
         counter <= 8'h00;
      end
      else
      begin
         unique case (state)
            adc_ctrl_pkg::ST_IDLE:
            begin
               counter <= 8'h00;
               if (swSampleSet || sampleAuto)
                  state <= adc_ctrl_pkg::ST_SAMPLE;
            end
            adc_ctrl_pkg::ST_SAMPLE:
            begin
               counter <= startConv ? 8'h00 : counter + 8'h01;
               if (startConv)
                  state <= adc_ctrl_pkg::ST_CONVERT;
            end
            adc_ctrl_pkg::ST_CONVERT:
            begin
               counter <= convEnd ? 8'h00 : counter + 8'h01;
               if (convEnd)
                  state <= sampleAuto ? adc_ctrl_pkg::ST_SAMPLE
                     : adc_ctrl_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Sample enable mirrors the acquire phase
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         sampleEnable <= 1'b0;
      else if (startConv)
         sampleEnable <= 1'b0;
      else if (state == adc_ctrl_pkg::ST_IDLE && (swSampleSet || sampleAuto))
         sampleEnable <= 1'b1;
      else if (convEnd && sampleAuto)
         sampleEnable <= 1'b1;
   end

   // Done flag: hardware set wins over software clear
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         convDone <= 1'b0;
      else if (convEnd)
         convDone <= 1'b1;
      else if (startConv)
         convDone <= 1'b0;
      else if (doneSwClr)
         convDone <= 1'b0;
   end

   // Channel stepping for sequential multi-channel sampling
   wire logic multi = channelCount != 2'h0;
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         chanIdx <= 2'h0;
      else if (state != adc_ctrl_pkg::ST_CONVERT)
         chanIdx <= 2'h0;
      else if (multi && !simSample && chanIdx != channelCount)
         chanIdx <= chanIdx + 2'h1;
   end

   // Converter-side outputs
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         sampling <= 1'b0;
         convertStart <= 1'b0;
         simultaneous <= 1'b0;
         channelSample <= 2'h0;
      end
      else
      begin
         sampling <= sampleEnable;
         convertStart <= startConv;
         simultaneous <= multi & simSample;
         channelSample <= chanIdx;
      end
   end

   // Interrupts: sticky, write one to clear, set wins
   wire logic [adc_ctrl_pkg::IRQ_W-1:0] irqEvent = {startConv, convEnd};
   wire logic irqStWr = wrPend && addrPend == adc_ctrl_pkg::ADDR_IRQ_STATUS;
   wire logic irqMkWr = wrPend && addrPend == adc_ctrl_pkg::ADDR_IRQ_MASK;
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         irqStatus <= '0;
         irqMask <= '0;
         irq <= 1'b0;
      end
      else
      begin
         irqStatus <= irqEvent | (irqStatus
            & ~(irqStWr ? hwdata[adc_ctrl_pkg::IRQ_W-1:0] : '0));
         if (irqMkWr)
            irqMask <= hwdata[adc_ctrl_pkg::IRQ_W-1:0];
         irq <= |(irqStatus & irqMask);
      end
   end

   // Read data
   logic [31:0] readValue;
   always_comb
   begin
      readValue = 32'h0000_0000;
      unique case (addrPend)
         adc_ctrl_pkg::ADDR_CONTROL_1:
         begin
            readValue[adc_ctrl_pkg::TRIG_MSB:adc_ctrl_pkg::TRIG_LSB] =
               triggerSource;
            readValue[adc_ctrl_pkg::BIT_SIM_SAMPLE] = simSample;
            readValue[adc_ctrl_pkg::BIT_SAMPLE_AUTO] = sampleAuto;
            readValue[adc_ctrl_pkg::BIT_SAMPLE_ENABLE] = sampleEnable;
            readValue[adc_ctrl_pkg::BIT_CONV_DONE] = convDone;
            readValue[adc_ctrl_pkg::BIT_RESOLUTION] = resolution;
         end
         adc_ctrl_pkg::ADDR_IRQ_STATUS:
            readValue[adc_ctrl_pkg::IRQ_W-1:0] = irqStatus;
         adc_ctrl_pkg::ADDR_IRQ_MASK:
            readValue[adc_ctrl_pkg::IRQ_W-1:0] = irqMask;
         adc_ctrl_pkg::ADDR_CONFIG:
         begin
            readValue[adc_ctrl_pkg::CHANNEL_COUNT_SELECT_MSB:adc_ctrl_pkg::CHANNEL_COUNT_SELECT_LSB] =
               channelCount;
            readValue[adc_ctrl_pkg::ACNT_MSB:adc_ctrl_pkg::ACNT_LSB] =
               autoCount;
            readValue[adc_ctrl_pkg::CONV_MSB:adc_ctrl_pkg::CONV_LSB] =
               convCycles;
         end
         default: readValue = 32'h0000_0000;
      endcase
   end

   // Registered read data lands one cycle after the address phase
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
      else
      begin
         hreadyout <= ~(addrValid & ~hwrite);
         hresp <= 1'b0;
         if (rdPend)
            hrdata <= readValue;
      end
   end
endmodule // adc_sample_convert_control
`default_nettype wire

/* adc_ctrl_pkg.sv */
package adc_ctrl_pkg;
   // Register byte addresses
   localparam logic [11:0] ADDR_CONTROL_1 = 12'h000;
   localparam logic [11:0] ADDR_IRQ_STATUS = 12'h004;
   localparam logic [11:0] ADDR_IRQ_MASK = 12'h008;
   localparam logic [11:0] ADDR_CONFIG = 12'h00C;
   // Control register 1 field positions
   localparam int BIT_CONV_DONE = 0;
   localparam int BIT_SAMPLE_ENABLE = 1;
   localparam int BIT_SAMPLE_AUTO = 2;
   localparam int BIT_SIM_SAMPLE = 3;
   localparam int TRIG_LSB = 5;
   localparam int TRIG_MSB = 7;
   localparam int BIT_RESOLUTION = 10;
   // Config register fields
   localparam int CHANNEL_COUNT_SELECT_LSB = 0;
   localparam int CHANNEL_COUNT_SELECT_MSB = 1;
   localparam int ACNT_LSB = 8;
   localparam int ACNT_MSB = 12;
   localparam int CONV_LSB = 16;
   localparam int CONV_MSB = 23;
   // Interrupt bits
   localparam int IRQ_DONE = 0;
   localparam int IRQ_START = 1;
   localparam int IRQ_W = 2;
   // Trigger source codes
   localparam logic [2:0] TRIG_SOFT = 3'h0;
   localparam logic [2:0] TRIG_EXT0 = 3'h1;
   localparam logic [2:0] TRIG_TMR3 = 3'h2;
   localparam logic [2:0] TRIG_PWM1 = 3'h3;
   localparam logic [2:0] TRIG_PWM2 = 3'h5;
   localparam logic [2:0] TRIG_AUTO = 3'h7;
   // Reset values, then the NONSEQ transfer code and the state type
   localparam logic [4:0] AUTO_COUNT_RESET = 5'h03;
   localparam logic [7:0] CONV_CYCLES_RESET = 8'h0E;
   localparam logic [1:0] CHANNEL_COUNT_SELECT_RESET = 2'h0;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   typedef enum {ST_IDLE, ST_SAMPLE, ST_CONVERT} conv_state_t;
endpackage

/* trig_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface trig_if;
   logic rawExt0;
   logic rawTmr3;
   logic rawPwm1;
   logic rawPwm2;
   logic ext0Edge;
   logic tmr3Pulse;
   logic pwm1Pulse;
   logic pwm2Pulse;
   modport sync (input rawExt0, rawTmr3, rawPwm1, rawPwm2,
      output ext0Edge, tmr3Pulse, pwm1Pulse, pwm2Pulse);
   modport core (output rawExt0, rawTmr3, rawPwm1, rawPwm2,
      input ext0Edge, tmr3Pulse, pwm1Pulse, pwm2Pulse);
endinterface
`default_nettype wire

/* trig_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module trig_sync
(
   // System
   input wire logic clk,
   input wire logic rstn,
   // Triggers
   trig_if.sync trig
);
   logic [3:0] meta;
   logic [3:0] stable;
   logic [3:0] prev;
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         meta <= 4'h0;
         stable <= 4'h0;
         prev <= 4'h0;
      end
      else
      begin
         meta <= {trig.rawPwm2, trig.rawPwm1, trig.rawTmr3, trig.rawExt0};
         stable <= meta;
         prev <= stable;
      end
   end
   // Rising edges only; sources are levels from other clock domains
   assign trig.ext0Edge = stable[0] & ~prev[0];
   assign trig.tmr3Pulse = stable[1] & ~prev[1];
   assign trig.pwm1Pulse = stable[2] & ~prev[2];
   assign trig.pwm2Pulse = stable[3] & ~prev[3];
endmodule // trig_sync
`default_nettype wire

/* adc_sample_convert_control_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module adc_sample_convert_control_sva
(
   // System
   input wire logic clk,
   input wire logic rstn,
   // Bus
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   // Converter side
   input wire logic sampling,
   input wire logic convertStart
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);
   a_resp_always_okay: assert property (hresp == 1'b0)
      else $error("bad response");
   a_write_zero_wait: assert property
      (hsel && hready && htrans[1] && hwrite |=> hreadyout)
      else $error("write stalled");
   a_read_one_wait: assert property
      (hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read wait wrong");
   a_rdata_holds: assert property
      (hreadyout && $past(hreadyout) |-> $stable(hrdata))
      else $error("read data moved");
   a_end_starts_convert: assert property
      ($fell(sampling) |-> $past(convertStart))
      else $error("no start after sampling end");
   a_start_single_pulse: assert property (convertStart |=> !convertStart)
      else $error("start pulse too long");
   a_hold_while_convert: assert property (convertStart |=> !sampling)
      else $error("sampling during conversion");
   a_no_early_resample: assert property
      (convertStart |=> !sampling [*8])
      else $error("sampling resumed early");
   a_start_needs_sample: assert property
      ($rose(convertStart) |-> sampling)
      else $error("start without sampling");
endmodule // adc_sample_convert_control_sva
bind adc_sample_convert_control adc_sample_convert_control_sva chk_u
(
   .clk(clk),
   .rstn(rstn),
   .hsel(hsel),
   .htrans(htrans),
   .hwrite(hwrite),
   .hready(hready),
   .hrdata(hrdata),
   .hreadyout(hreadyout),
   .hresp(hresp),
   .sampling(sampling),
   .convertStart(convertStart)
);
`default_nettype wire

/* adc_sample_convert_control_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin \
   n_errors++; $display("MISMATCH %0t got %0h exp %0h", $time, got, exp); \
   end end
module adc_sample_convert_control_tb;
   localparam logic [11:0] CTL = adc_ctrl_pkg::ADDR_CONTROL_1;
   localparam logic [11:0] STS = adc_ctrl_pkg::ADDR_IRQ_STATUS;
   localparam logic [11:0] MSK = adc_ctrl_pkg::ADDR_IRQ_MASK;
   localparam logic [11:0] CFG = adc_ctrl_pkg::ADDR_CONFIG;
   logic clk, rstn, hsel, hwrite, hreadyout, hresp;
   logic sampling, convertStart, simultaneous, irq;
   logic [11:0] haddr;
   logic [1:0] htrans, channelSample;
   logic [2:0] hsize;
   logic [31:0] hwdata, hrdata, rd;
   logic [3:0] pins;
   int n_errors = 0;
   int checks_done = 0;

   adc_sample_convert_control dut_u
   (
      .clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .extInt0(pins[0]), .timer3Compare(pins[1]),
      .pwm1Interval(pins[2]), .pwm2Interval(pins[3]),
      .sampling(sampling), .convertStart(convertStart),
      .simultaneous(simultaneous), .channelSample(channelSample), .irq(irq)
   );

   task automatic stop_test;
      if (n_errors == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // Entered just after a rising edge; hready is the slave's own ready
   task automatic busXfer(input logic [11:0] a, input logic w,
      input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= adc_ctrl_pkg::HTRANS_NONSEQ;
      do @(posedge clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   task automatic busWrite(input logic [11:0] a, input logic [31:0] d);
      busXfer(a, 1'b1, d);
   endtask

   task automatic busRead(input logic [11:0] a);
      busXfer(a, 1'b0, 32'h0000_0000);
   endtask

   // Sampled at the falling edge so the rising edge's updates have landed
   task automatic waitFor(input bit onSample, input int n);
      int i;
      logic v;
      v = 1'b0;
      for (i = 0; i < n && v !== 1'b1; i++)
      begin
         @(negedge clk);
         v = onSample ? sampling : convertStart;
      end
      `CHK(v, 1'b1)
      @(posedge clk);
   endtask

   task automatic waitDone;
      int i;
      rd = 32'h0;
      for (i = 0; i < 40 && rd[0] !== 1'b1; i++)
         busRead(CTL);
      `CHK(rd[0], 1'b1)
   endtask

   task automatic testReset;
      busRead(CTL);
      `CHK(rd, 32'h0000_0000)
      busWrite(12'h010, 32'hFFFF_FFFF);
      busRead(12'h010);
      `CHK(rd, 32'h0000_0000)
      `CHK(irq, 1'b0)
   endtask

   task automatic testSoftware;
      busWrite(MSK, 32'h0000_0001);
      busWrite(CTL, 32'h0000_0002);
      waitFor(1'b1, 3);
      busRead(CTL);
      `CHK(rd[1], 1'b1)
      busWrite(CTL, 32'h0000_0000);
      waitFor(1'b0, 4);
      busRead(CTL);
      `CHK(rd[1:0], 2'b00)
      waitDone();
      `CHK(sampling, 1'b0)
      repeat (2) @(posedge clk);
      `CHK(irq, 1'b1)
      busWrite(MSK, 32'h0000_0000);
      repeat (2) @(posedge clk);
      `CHK(irq, 1'b0)
      busWrite(MSK, 32'h0000_0001);
      busWrite(STS, 32'h0000_0003);
      repeat (2) @(posedge clk);
      `CHK(irq, 1'b0)
      busRead(STS);
      `CHK(rd[1:0], 2'b00)
      busWrite(CTL, 32'h0000_0000);
      busRead(CTL);
      `CHK(rd[0], 1'b0)
      busWrite(CTL, 32'h0000_0001);
      busRead(CTL);
      `CHK(rd[0], 1'b0)
   endtask

   // Each pin is held until the start shows, covering the sync delay
   task automatic testTriggers;
      logic [2:0] codes [4];
      int k;
      codes = '{adc_ctrl_pkg::TRIG_EXT0, adc_ctrl_pkg::TRIG_TMR3,
         adc_ctrl_pkg::TRIG_PWM1, adc_ctrl_pkg::TRIG_PWM2};
      for (k = 0; k < 4; k++)
      begin
         // Done written as one so only the start can clear it
         busWrite(CTL, {24'h0, codes[k], 5'h03});
         waitFor(1'b1, 3);
         busRead(CTL);
         `CHK(rd[1:0], (k == 0) ? 2'b10 : 2'b11)
         pins[k] <= 1'b1;
         waitFor(1'b0, 12);
         pins[k] <= 1'b0;
         busRead(CTL);
         `CHK(rd[1:0], 2'b00)
         waitDone();
      end
   endtask

   // Pins drop between codes so each code sees fresh edges
   task automatic testReserved;
      logic seen;
      int k;
      seen = 1'b0;
      for (k = 0; k < 2; k++)
      begin
         busWrite(CTL, (k == 0) ? 32'h0000_0082 : 32'h0000_00C2);
         pins <= 4'hF;
         repeat (20)
         begin
            @(negedge clk);
            seen = seen | convertStart;
         end
         @(posedge clk);
         pins <= 4'h0;
      end
      `CHK(seen, 1'b0)
      `CHK(sampling, 1'b1)
      busWrite(CTL, 32'h0000_0002);
      busWrite(CTL, 32'h0000_0000);
      waitDone();
   endtask

   // Long auto count so bus writes land inside one sampling phase
   task automatic testAuto;
      busWrite(CFG, 32'h000E_1F00);
      busWrite(CTL, 32'h0000_00E6);
      waitFor(1'b0, 50);
      waitFor(1'b1, 30);
      busWrite(CTL, 32'h0000_00E6);
      busRead(CTL);
      `CHK(rd[1:0], 2'b10)
      waitFor(1'b0, 50);
      busWrite(CFG, 32'h000E_1F01);
      busWrite(CTL, 32'h0000_0008);
      repeat (2) @(posedge clk);
      `CHK(simultaneous, 1'b1)
      waitDone();
      busWrite(CTL, 32'h0000_0002);
      waitFor(1'b1, 3);
      busWrite(CTL, 32'h0000_0000);
      waitFor(1'b0, 4);
      repeat (2) @(posedge clk);
      `CHK(channelSample, 2'h1)
      `CHK(simultaneous, 1'b0)
   endtask

   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   initial
   begin
      #(20000 * 100);
      n_errors++;
      $display("MISMATCH %0t watchdog expired", $time);
      stop_test();
   end

   initial
   begin
      rstn = 1'b0;
      hsel = 1'b0;
      haddr = 12'h000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      pins = 4'h0;
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      testReset();
      testSoftware();
      testTriggers();
      testReserved();
      testAuto();
      stop_test();
   end
endmodule // adc_sample_convert_control_tb
`undef CHK
`default_nettype wire
